// file: core/hs_lane_ctrl_map.vh
// Register map, field positions, reset values and management frame constants for the lane control bank
`ifndef HS_LANE_CTRL_MAP_VH
`define HS_LANE_CTRL_MAP_VH

// Management device and register offsets
`define LANE_DEVAD 5'h1E
`define CHAN_CTRL_OFS 16'h0001
`define TX_RX_ENABLE_RATE_OFS 16'h0003
`define RX_TUNING_OFS 16'h0004

// Reset values
`define TX_RX_ENABLE_RATE_RST 16'hA848
`define RX_TUNING_RST 16'h1500
`define CHAN_PD_RST 1'b0

// Channel control: global power-down bit
`define CHAN_PD_BIT 15

// Enable/rate register field positions
`define DRIVE_LEVEL_HI 15
`define DRIVE_LEVEL_LO 12
`define TX_ON_BIT 11
`define EQ_FREEZE_BIT 10
`define TX_RATE_HI 9
`define TX_RATE_LO 8
`define GAIN_POL_HI 7
`define GAIN_POL_LO 6
`define OFS_CAL_HI 5
`define OFS_CAL_LO 4
`define RX_ON_BIT 3
`define RX_RATE_HI 2
`define RX_RATE_LO 0

// Rx tuning register field positions
`define TRACK_BIT 15
`define PRECURSOR_HI 14
`define PRECURSOR_LO 12
`define CDR_ORDER_HI 11
`define CDR_ORDER_LO 10
`define CDR_VOTES_HI 9
`define CDR_VOTES_LO 8
`define HF_BOOST_OFF_BIT 6
`define SHORT_CH_BIT 5
`define CURSOR_RED_HI 4
`define CURSOR_RED_LO 0

// Field codes
`define PRECURSOR_OFF 3'h7
`define CURSOR_RES_LO 5'h07
`define CURSOR_RES_HI 5'h0F
`define CDR_ORDER_RES 2'h3

// Management frame
`define PREAMBLE_ONES 6'h20
`define HDR_BITS 4'hD
`define DATA_LAST 4'hF
`define OP_ADDR 2'h0
`define OP_WRITE 2'h1
`define OP_READ_INC 2'h2
`define OP_READ 2'h3

`endif

// file: core/hs_lane_ctrl_regs.v
// Management-bus slave holding the high-speed lane enable/rate and rx tuning registers
`timescale 1ns/10ps
`include "hs_lane_ctrl_map.vh"
module hs_lane_ctrl_regs (
   input wire ref_clk_i,
   input wire nrst_i,
   input wire [4:0] port_addr_i,
   input wire mdc_i,
   input wire mdio_i,
   output reg mdio_o,
   output reg mdio_oe_o,
   input wire chan_powerdown_pin_n_i,
   input wire ref_rate_choice_bit_i,
   input wire rate_manual_enable_i,
   input wire [2:0] auto_rx_rate_i,
   output reg datapath_powerdown_o,
   output reg [3:0] tx_drive_level_o,
   output reg line_tx_on_o,
   output reg line_rx_on_o,
   output reg equalizer_freeze_o,
   output reg [1:0] tx_rate_divider_o,
   output reg [1:0] gain_loop_policy_o,
   output reg [1:0] offset_cal_policy_o,
   output reg [2:0] rx_rate_divider_o,
   output reg rx_rate_reserved_o,
   output reg adc_track_force_o,
   output reg [2:0] rx_precursor_strength_o,
   output reg rx_precursor_off_o,
   output reg [1:0] clock_recovery_order_o,
   output reg clock_recovery_order_reserved_o,
   output reg [1:0] clock_recovery_votes_o,
   output reg hf_boost_off_o,
   output reg short_channel_recovery_o,
   output reg [4:0] tx_cursor_reduction_o,
   output reg tx_cursor_reduction_reserved_o
);

   // Frame state codes
   localparam [1:0] ST_PRE = 2'd0;
   localparam [1:0] ST_HDR = 2'd1;
   localparam [1:0] ST_TA = 2'd2;
   localparam [1:0] ST_DATA = 2'd3;

   // Stored registers
   reg [15:0] enable_rate_q;
   reg [15:0] rx_tuning_q;
   reg chan_pd_q;

   // Management frame engine state
   reg [1:0] state_q;
   reg mdc_q;
   reg [5:0] ones_q;
   reg [3:0] cnt_q;
   reg [12:0] hdr_q;
   reg [15:0] wsh_q;
   reg [15:0] rsh_q;
   reg [15:0] addr_q;
   reg frame_ok_q;

   wire mdc_rise;
   wire [1:0] hdr_op;
   wire [4:0] hdr_prt;
   wire [4:0] hdr_dev;
   wire [15:0] wr_word;
   wire [2:0] rx_rate_field;
   wire rx_rate_manual;
   wire tx_on_eff;
   wire rx_on_eff;

   // Frame is ours when the clause 45 start, port and device all match
   function frame_match;
      input st1;
      input [4:0] prt;
      input [4:0] dev;
      input [4:0] own;
      begin
         frame_match = (st1 == 1'b0) && (prt == own) && (dev == `LANE_DEVAD);
      end
   endfunction

   // Read multiplexer; unmapped offsets in this device read as zero
   function [15:0] read_mux;
      input [15:0] ofs;
      input [15:0] en_rate;
      input [15:0] tuning;
      input pd;
      begin
         if (ofs == `TX_RX_ENABLE_RATE_OFS) begin
            read_mux = en_rate;
         end else if (ofs == `RX_TUNING_OFS) begin
            read_mux = tuning;
         end else if (ofs == `CHAN_CTRL_OFS) begin
            read_mux = {pd, 15'h0000};
         end else begin
            read_mux = 16'h0000;
         end
      end
   endfunction

   // Data path is down for the pin or the global bit; management keeps running
   function path_down;
      input pin_n;
      input pd;
      begin
         path_down = ~pin_n | pd;
      end
   endfunction

   // Lane enable gated by power-down, shared by transmitter and receiver
   function lane_enable;
      input en;
      input pin_n;
      input pd;
      begin
         lane_enable = en & ~path_down(pin_n, pd);
      end
   endfunction

   // Receive rate codes 01x and 100 are reserved; 001 is taken as half rate
   function rate_reserved;
      input [2:0] code;
      begin
         rate_reserved = (code[2:1] == 2'b01) || (code == 3'b100);
      end
   endfunction

   // Precursor code 111 turns the precursor equalizer off
   function precursor_off;
      input [2:0] code;
      begin
         precursor_off = (code == `PRECURSOR_OFF);
      end
   endfunction

   // Loop order code 11 has no defined behaviour
   function order_reserved;
      input [1:0] code;
      begin
         order_reserved = (code == `CDR_ORDER_RES);
      end
   endfunction

   // Cursor reduction codes 00111 to 01111 are reserved
   function cursor_reserved;
      input [4:0] code;
      begin
         cursor_reserved = (code >= `CURSOR_RES_LO) && (code <= `CURSOR_RES_HI);
      end
   endfunction

   // Header fields as sampled: start bit, op, port, device
   assign hdr_op = hdr_q[11:10];
   assign hdr_prt = hdr_q[9:5];
   assign hdr_dev = hdr_q[4:0];
   assign mdc_rise = mdc_i & ~mdc_q;
   assign wr_word = {wsh_q[14:0], mdio_i};

   // Management clock edge detect; mdc must be well below the 40 MHz clock
   always @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mdc_q <= 1'b0;
      end else begin
         mdc_q <= mdc_i;
      end
   end

   // Frame engine: preamble, header, turnaround, data, and register writes
   always @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= ST_PRE;
         ones_q <= 6'h00;
         cnt_q <= 4'h0;
         hdr_q <= 13'h0000;
         wsh_q <= 16'h0000;
         rsh_q <= 16'h0000;
         addr_q <= 16'h0000;
         frame_ok_q <= 1'b0;
         mdio_o <= 1'b0;
         mdio_oe_o <= 1'b0;
         enable_rate_q <= `TX_RX_ENABLE_RATE_RST;
         rx_tuning_q <= `RX_TUNING_RST;
         chan_pd_q <= `CHAN_PD_RST;
      end else if (mdc_rise) begin
         case (state_q)
            ST_PRE: begin
               // Preamble suppression is not supported: 32 ones before every frame
               if (mdio_i) begin
                  if (ones_q != `PREAMBLE_ONES) begin
                     ones_q <= ones_q + 6'h01;
                  end
               end else if (ones_q == `PREAMBLE_ONES) begin
                  state_q <= ST_HDR;
                  cnt_q <= 4'h0;
                  ones_q <= 6'h00;
               end else begin
                  ones_q <= 6'h00;
               end
            end
            ST_HDR: begin
               hdr_q <= {hdr_q[11:0], mdio_i};
               if (cnt_q == `HDR_BITS - 4'h1) begin
                  state_q <= ST_TA;
                  cnt_q <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            ST_TA: begin
               if (cnt_q == 4'h0) begin
                  // First turnaround bit: take the read word, start driving zero
                  frame_ok_q <= frame_match(hdr_q[12], hdr_prt, hdr_dev, port_addr_i);
                  rsh_q <= read_mux(addr_q, enable_rate_q, rx_tuning_q, chan_pd_q);
                  cnt_q <= 4'h1;
                  if (frame_match(hdr_q[12], hdr_prt, hdr_dev, port_addr_i) && hdr_op[1]) begin
                     mdio_oe_o <= 1'b1;
                     mdio_o <= 1'b0;
                  end
               end else begin
                  // Second turnaround bit: present the first data bit
                  state_q <= ST_DATA;
                  cnt_q <= 4'h0;
                  if (mdio_oe_o) begin
                     mdio_o <= rsh_q[15];
                     rsh_q <= {rsh_q[14:0], 1'b0};
                  end
               end
            end
            default: begin
               wsh_q <= wr_word;
               if (cnt_q != `DATA_LAST) begin
                  cnt_q <= cnt_q + 4'h1;
                  if (mdio_oe_o) begin
                     mdio_o <= rsh_q[15];
                     rsh_q <= {rsh_q[14:0], 1'b0};
                  end
               end else begin
                  // Last data bit: release the line and commit the frame
                  state_q <= ST_PRE;
                  cnt_q <= 4'h0;
                  mdio_oe_o <= 1'b0;
                  mdio_o <= 1'b0;
                  if (frame_ok_q) begin
                     if (hdr_op == `OP_ADDR) begin
                        addr_q <= wr_word;
                     end else if (hdr_op == `OP_READ_INC) begin
                        addr_q <= addr_q + 16'h0001;
                     end else if (hdr_op == `OP_WRITE) begin
                        // Full-width store for enable/rate and tuning, reserved codes and bits kept as written; channel control keeps bit 15 only
                        if (addr_q == `TX_RX_ENABLE_RATE_OFS) begin
                           enable_rate_q <= wr_word;
                        end else if (addr_q == `RX_TUNING_OFS) begin
                           rx_tuning_q <= wr_word;
                        end else if (addr_q == `CHAN_CTRL_OFS) begin
                           chan_pd_q <= wr_word[`CHAN_PD_BIT];
                        end
                     end
                  end
               end
            end
         endcase
      end
   end

   // Rate rate_manual_enable and effective enables
   assign rx_rate_field = enable_rate_q[`RX_RATE_HI:`RX_RATE_LO];
   assign rx_rate_manual = ref_rate_choice_bit_i | rate_manual_enable_i;
   assign tx_on_eff = lane_enable(enable_rate_q[`TX_ON_BIT], chan_powerdown_pin_n_i, chan_pd_q);
   assign rx_on_eff = lane_enable(enable_rate_q[`RX_ON_BIT], chan_powerdown_pin_n_i, chan_pd_q);

   // Lane controls registered so every output leaves a flip-flop; one cycle behind the store
   always @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         datapath_powerdown_o <= 1'b0;
         tx_drive_level_o <= 4'h0;
         line_tx_on_o <= 1'b0;
         line_rx_on_o <= 1'b0;
         equalizer_freeze_o <= 1'b0;
         tx_rate_divider_o <= 2'h0;
         gain_loop_policy_o <= 2'h0;
         offset_cal_policy_o <= 2'h0;
         rx_rate_divider_o <= 3'h0;
         rx_rate_reserved_o <= 1'b0;
         adc_track_force_o <= 1'b0;
         rx_precursor_strength_o <= 3'h0;
         rx_precursor_off_o <= 1'b0;
         clock_recovery_order_o <= 2'h0;
         clock_recovery_order_reserved_o <= 1'b0;
         clock_recovery_votes_o <= 2'h0;
         hf_boost_off_o <= 1'b0;
         short_channel_recovery_o <= 1'b0;
         tx_cursor_reduction_o <= 5'h00;
         tx_cursor_reduction_reserved_o <= 1'b0;
      end else begin
         // Power state follows the pin one cycle late, like every other lane control
         datapath_powerdown_o <= path_down(chan_powerdown_pin_n_i, chan_pd_q);
         // Enable/rate register fields
         tx_drive_level_o <= enable_rate_q[`DRIVE_LEVEL_HI:`DRIVE_LEVEL_LO];
         line_tx_on_o <= tx_on_eff;
         line_rx_on_o <= rx_on_eff;
         equalizer_freeze_o <= enable_rate_q[`EQ_FREEZE_BIT];
         tx_rate_divider_o <= enable_rate_q[`TX_RATE_HI:`TX_RATE_LO];
         gain_loop_policy_o <= enable_rate_q[`GAIN_POL_HI:`GAIN_POL_LO];
         offset_cal_policy_o <= enable_rate_q[`OFS_CAL_HI:`OFS_CAL_LO];
         // Automatic rate unless software takes it over
         rx_rate_divider_o <= rx_rate_manual ? rx_rate_field : auto_rx_rate_i;
         // 001 taken as half rate; 01x and 100 flagged only while rx_rate_manual is set
         rx_rate_reserved_o <= rx_rate_manual && rate_reserved(rx_rate_field);
         // Tuning register fields; reserved codes pass through and are only flagged
         adc_track_force_o <= rx_tuning_q[`TRACK_BIT];
         rx_precursor_strength_o <= rx_tuning_q[`PRECURSOR_HI:`PRECURSOR_LO];
         rx_precursor_off_o <= precursor_off(rx_tuning_q[`PRECURSOR_HI:`PRECURSOR_LO]);
         clock_recovery_order_o <= rx_tuning_q[`CDR_ORDER_HI:`CDR_ORDER_LO];
         clock_recovery_order_reserved_o <= order_reserved(rx_tuning_q[`CDR_ORDER_HI:`CDR_ORDER_LO]);
         clock_recovery_votes_o <= rx_tuning_q[`CDR_VOTES_HI:`CDR_VOTES_LO];
         hf_boost_off_o <= rx_tuning_q[`HF_BOOST_OFF_BIT];
         short_channel_recovery_o <= rx_tuning_q[`SHORT_CH_BIT];
         tx_cursor_reduction_o <= rx_tuning_q[`CURSOR_RED_HI:`CURSOR_RED_LO];
         tx_cursor_reduction_reserved_o <= cursor_reserved(rx_tuning_q[`CURSOR_RED_HI:`CURSOR_RED_LO]);
      end
   end

endmodule

// file: dv/hs_lane_ctrl_assertions.sv
// Port-level checker for the lane control bank
`timescale 1ns/10ps
module hs_lane_ctrl_assertions (
   input wire ref_clk_i,
   input wire nrst_i,
   input wire chan_powerdown_pin_n_i,
   input wire ref_rate_choice_bit_i,
   input wire rate_manual_enable_i,
   input wire [2:0] auto_rx_rate_i,
   input wire datapath_powerdown_o,
   input wire line_tx_on_o,
   input wire line_rx_on_o,
   input wire [2:0] rx_rate_divider_o,
   input wire rx_rate_reserved_o,
   input wire [2:0] rx_precursor_strength_o,
   input wire rx_precursor_off_o,
   input wire [1:0] clock_recovery_order_o,
   input wire clock_recovery_order_reserved_o,
   input wire [4:0] tx_cursor_reduction_o,
   input wire tx_cursor_reduction_reserved_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   // Enables only while the pin was high and power-down is off
   AST_TX_ON: assert property (line_tx_on_o |-> $past(chan_powerdown_pin_n_i) && !datapath_powerdown_o)
      else $error("tx enable while powered down");
   AST_RX_ON: assert property (line_rx_on_o |-> $past(chan_powerdown_pin_n_i) && !datapath_powerdown_o)
      else $error("rx enable while powered down");
   // First edge after reset still sees the reset value, hence the past reset term
   AST_PIN_PD: assert property ($past(nrst_i) && !$past(chan_powerdown_pin_n_i) |-> datapath_powerdown_o)
      else $error("pin low without power-down");
   AST_AUTO_RATE: assert property ($past(nrst_i) && !$past(ref_rate_choice_bit_i) && !$past(rate_manual_enable_i)
      |-> rx_rate_divider_o == $past(auto_rx_rate_i) && !rx_rate_reserved_o)
      else $error("rx rate not automatic");
   AST_MAN_RES: assert property ($past(nrst_i) && ($past(ref_rate_choice_bit_i) || $past(rate_manual_enable_i))
      |-> rx_rate_reserved_o == (rx_rate_divider_o inside {3'h2, 3'h3, 3'h4}))
      else $error("rx rate reserved flag wrong");
   AST_PRE_OFF: assert property (rx_precursor_off_o == (rx_precursor_strength_o == 3'h7))
      else $error("precursor off flag wrong");
   AST_ORD_RES: assert property (clock_recovery_order_reserved_o == (clock_recovery_order_o == 2'h3))
      else $error("loop order flag wrong");
   AST_CUR_RES: assert property (tx_cursor_reduction_reserved_o == (tx_cursor_reduction_o inside {[5'h07:5'h0F]}))
      else $error("cursor reserved flag wrong");
endmodule
bind hs_lane_ctrl_regs hs_lane_ctrl_assertions u_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
   .chan_powerdown_pin_n_i(chan_powerdown_pin_n_i), .ref_rate_choice_bit_i(ref_rate_choice_bit_i),
   .rate_manual_enable_i(rate_manual_enable_i), .auto_rx_rate_i(auto_rx_rate_i),
   .datapath_powerdown_o(datapath_powerdown_o), .line_tx_on_o(line_tx_on_o), .line_rx_on_o(line_rx_on_o),
   .rx_rate_divider_o(rx_rate_divider_o), .rx_rate_reserved_o(rx_rate_reserved_o),
   .rx_precursor_strength_o(rx_precursor_strength_o), .rx_precursor_off_o(rx_precursor_off_o),
   .clock_recovery_order_o(clock_recovery_order_o), .clock_recovery_order_reserved_o(clock_recovery_order_reserved_o),
   .tx_cursor_reduction_o(tx_cursor_reduction_o), .tx_cursor_reduction_reserved_o(tx_cursor_reduction_reserved_o));

// file: dv/lane_mdio_station.sv
// Management station model for the lane control bank
`timescale 1ns/10ps
`include "hs_lane_ctrl_map.vh"
module lane_mdio_station #(parameter [4:0] PRT = 5'h05) (
   input wire ref_clk_i,
   input wire mdio_i,
   output reg mdc_o = 1'b0,
   output reg mdio_o = 1'b1
);
   // One frame, four ref clocks per mdc phase; line released from turnaround on reads
   task frame(input [1:0] op, input [4:0] prt, input [4:0] dev, input [15:0] val, output [15:0] rd);
      reg [63:0] bits;
      integer i;
      begin
         bits = {32'hFFFFFFFF, 2'b00, op, prt, dev, 2'b10, val};
         for (i = 63; i >= 0; i = i - 1) begin
            mdio_o = (op[1] && i < 18) ? 1'b1 : bits[i];
            repeat (4) @(negedge ref_clk_i);
            if (i < 16) rd[i] = mdio_i;
            mdc_o = 1'b1;
            repeat (4) @(negedge ref_clk_i);
            mdc_o = 1'b0;
         end
         // Back to the pull-up level, one idle clock so no pin changes twice in a step
         mdio_o = 1'b1;
         @(negedge ref_clk_i);
      end
   endtask
   task reg_wr(input [15:0] ofs, input [15:0] val);
      reg [15:0] nc;
      begin
         frame(`OP_ADDR, PRT, `LANE_DEVAD, ofs, nc);
         frame(`OP_WRITE, PRT, `LANE_DEVAD, val, nc);
      end
   endtask
   task reg_rd(input [15:0] ofs, output [15:0] val);
      begin
         frame(`OP_ADDR, PRT, `LANE_DEVAD, ofs, val);
         frame(`OP_READ, PRT, `LANE_DEVAD, 16'h0000, val);
      end
   endtask
endmodule

// file: dv/hs_lane_ctrl_regs_tb.sv
// Self-checking bench for the lane control register bank
`timescale 1ns/10ps
`include "hs_lane_ctrl_map.vh"
module hs_lane_ctrl_regs_tb;
   localparam [4:0] PRT = 5'h05;
   reg clk = 1'b0;
   reg nrst = 1'b0;
   reg pin_n = 1'b1;
   reg choice = 1'b1;
   reg manual = 1'b0;
   reg [2:0] auto_rate = 3'h0;
   wire mdc, st_d, dut_d, dut_oe, pd;
   wire mdio_line = dut_oe ? dut_d : st_d; // Pull-up level when released
   wire [15:0] r3o, r4o;
   wire [3:0] flg;
   integer fail_count = 0;
   integer checks = 0;
   reg [15:0] rd;
   assign r4o[7] = 1'b0;
   always #12.5 clk = ~clk;
   // Lane outputs gathered back into register layout for whole-word compares
   hs_lane_ctrl_regs DUT (.ref_clk_i(clk), .nrst_i(nrst), .port_addr_i(PRT), .mdc_i(mdc), .mdio_i(mdio_line),
      .mdio_o(dut_d), .mdio_oe_o(dut_oe), .chan_powerdown_pin_n_i(pin_n), .ref_rate_choice_bit_i(choice),
      .rate_manual_enable_i(manual), .auto_rx_rate_i(auto_rate), .datapath_powerdown_o(pd),
      .tx_drive_level_o(r3o[15:12]), .line_tx_on_o(r3o[11]), .line_rx_on_o(r3o[3]), .equalizer_freeze_o(r3o[10]),
      .tx_rate_divider_o(r3o[9:8]), .gain_loop_policy_o(r3o[7:6]), .offset_cal_policy_o(r3o[5:4]),
      .rx_rate_divider_o(r3o[2:0]), .rx_rate_reserved_o(flg[0]), .adc_track_force_o(r4o[15]),
      .rx_precursor_strength_o(r4o[14:12]), .rx_precursor_off_o(flg[3]), .clock_recovery_order_o(r4o[11:10]),
      .clock_recovery_order_reserved_o(flg[2]), .clock_recovery_votes_o(r4o[9:8]), .hf_boost_off_o(r4o[6]),
      .short_channel_recovery_o(r4o[5]), .tx_cursor_reduction_o(r4o[4:0]), .tx_cursor_reduction_reserved_o(flg[1]));
   lane_mdio_station #(.PRT(PRT)) st (.ref_clk_i(clk), .mdio_i(mdio_line), .mdc_o(mdc), .mdio_o(st_d));
   task chk(input string nm, input [15:0] exp, input [15:0] got);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task rdchk(input string nm, input [15:0] ofs, input [15:0] exp);
      begin
         st.reg_rd(ofs, rd);
         chk(nm, exp, rd);
      end
   endtask
   task t_reset;
      begin
         rdchk("reg3 reset", `TX_RX_ENABLE_RATE_OFS, 16'hA848);
         rdchk("reg4 reset", `RX_TUNING_OFS, 16'h1500);
         chk("reg3 lanes", 16'hA848, r3o);
         chk("reg4 lanes", 16'h1500, r4o);
         $display("reset test done");
      end
   endtask
   // Every two-bit field walks 00..11, reserved codes included
   task t_fields;
      integer i;
      reg [15:0] p;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            p = i * 16'h5555;
            st.reg_wr(`TX_RX_ENABLE_RATE_OFS, p);
            st.reg_wr(`RX_TUNING_OFS, p);
            rdchk("reg3 readback", `TX_RX_ENABLE_RATE_OFS, p);
            rdchk("reg4 readback", `RX_TUNING_OFS, p);
            chk("reg3 lanes", p, r3o);
            chk("reg4 lanes", p & 16'hFF7F, r4o);
            chk("flags", {12'h000, p[14:12] == 3'h7, p[11:10] == 2'h3, p[4:0] >= 5'h07 && p[4:0] <= 5'h0F,
               p[2:1] == 2'h1 || p[2:0] == 3'h4}, {12'h000, flg});
         end
         $display("field test done");
      end
   endtask
   task t_power;
      begin
         st.reg_wr(`TX_RX_ENABLE_RATE_OFS, 16'hA848);
         pin_n = 1'b0;
         repeat (3) @(negedge clk);
         chk("pin low", 16'hA040, r3o);
         chk("pd pin", 16'h0001, {15'h0000, pd});
         pin_n = 1'b1;
         st.reg_wr(`CHAN_CTRL_OFS, 16'hFFFF);
         rdchk("chan ctrl", `CHAN_CTRL_OFS, 16'h8000);
         chk("global pd", 16'hA040, r3o);
         chk("pd global", 16'h0001, {15'h0000, pd});
         st.reg_wr(`CHAN_CTRL_OFS, 16'h0000);
         chk("pd off", 16'hA848, r3o);
         chk("pd clear", 16'h0000, {15'h0000, pd});
         $display("power test done");
      end
   endtask
   task t_rate;
      begin
         st.reg_wr(`TX_RX_ENABLE_RATE_OFS, 16'hA84A);
         choice = 1'b0;
         auto_rate = 3'h6;
         repeat (3) @(negedge clk);
         chk("auto rate", 16'h0006, {13'h0000, r3o[2:0]});
         manual = 1'b1;
         repeat (3) @(negedge clk);
         chk("manual rate", 16'h0002, {13'h0000, r3o[2:0]});
         chk("rate flag", 16'h0001, {15'h0000, flg[0]});
         $display("rate test done");
      end
   endtask
   // Read-increment walks from the enable/rate register to the tuning register
   task t_read_inc;
      begin
         st.frame(`OP_ADDR, PRT, `LANE_DEVAD, `TX_RX_ENABLE_RATE_OFS, rd);
         st.frame(`OP_READ_INC, PRT, `LANE_DEVAD, 16'h0000, rd);
         chk("read-inc first", 16'hA84A, rd);
         st.frame(`OP_READ, PRT, `LANE_DEVAD, 16'h0000, rd);
         chk("read-inc next", 16'hFFFF, rd);
         chk("line released", 16'h0000, {15'h0000, dut_oe});
         $display("read-inc test done");
      end
   endtask
   task t_refuse;
      begin
         st.frame(`OP_ADDR, 5'h06, `LANE_DEVAD, `RX_TUNING_OFS, rd);
         st.frame(`OP_WRITE, 5'h06, `LANE_DEVAD, 16'h0000, rd);
         rdchk("foreign port", `RX_TUNING_OFS, 16'hFFFF);
         rdchk("unmapped", 16'h0009, 16'h0000);
         $display("refuse test done");
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", checks, fail_count);
         if (fail_count == 0 && checks > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      t_reset;
      t_fields;
      t_power;
      t_rate;
      t_read_inc;
      t_refuse;
      final_report;
   end
   // Watchdog, about twice the expected run time of all tests
   initial begin
      repeat (60000) @(posedge clk);
      fail_count = fail_count + 1;
      final_report;
   end
endmodule
